/* shared/csd_pkg.sv */
// Shared constants and types for the processor-code I/O decoder
package csd_pkg;

   // Instruction word, bit 0 of the manual is the MSB here
   typedef struct packed {
      logic [2:0] cls;   // Instruction class
      logic [1:0] ac;    // Accumulator select
      logic [2:0] op;    // Transfer opcode
      logic [1:0] ctrl;  // Control pulse or skip select
      logic [5:0] dev;   // Device select
   } csd_instr_t;

   // Sequencer states
   typedef enum logic [1:0] {CSD_IDLE, CSD_XFER, CSD_CTRL, CSD_HALT} csd_state_t;

   // Field codes
   localparam logic [2:0] IO_CLASS = 3'h3;
   localparam logic [5:0] CPU_CODE = 6'h3f;
   localparam logic [2:0] OP_NONE = 3'h0;
   localparam logic [2:0] OP_RDA = 3'h1;
   localparam logic [2:0] OP_WRA = 3'h2;
   localparam logic [2:0] OP_RDB = 3'h3;
   localparam logic [2:0] OP_WRB = 3'h4;
   localparam logic [2:0] OP_RDC = 3'h5;
   localparam logic [2:0] OP_WRC = 3'h6;
   localparam logic [2:0] OP_SKIP = 3'h7;
   localparam logic [1:0] CT_NONE = 2'h0;
   localparam logic [1:0] CT_START = 2'h1;
   localparam logic [1:0] CT_CLEAR = 2'h2;
   localparam logic [1:0] CT_PULSE = 2'h3;

   // Register map, byte addresses
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_MASK = 4'h4;
   localparam logic [3:0] REG_STATE = 4'h8;
   localparam logic [3:0] REG_CTRL = 4'hc;

   // Status and mask bit positions
   localparam int EV_HALT = 0;
   localparam int EV_GLOBAL_IO_RESET_OP = 1;
   localparam int EV_PFAIL = 2;
   localparam int EV_MASKO = 3;
   localparam int EV_COUNT = 4;

   // Control register bits
   localparam int CT_PFCLR = 0;
   localparam int CT_RESTART = 1;

   // Reset values
   localparam logic [EV_COUNT-1:0] STATUS_RST = 4'h0;
   localparam logic [EV_COUNT-1:0] MASK_RST = 4'h0;

   // Pin synchroniser width: switches, power fail, restart
   localparam int PIN_W = 18;
   localparam int PIN_PF = 16;
   localparam int PIN_RS = 17;

endpackage

/* verilog/csd_decoder.sv */
// Processor-code (device 77) I/O instruction decoder and executor
`timescale 1ns/1ps
`default_nettype none

module csd_decoder (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Instruction issue from the processor core
   input wire logic exec,
   input wire csd_pkg::csd_instr_t instr,
   input wire logic [15:0] acSel,
   input wire logic [15:0] acZero,
   input wire logic instrDone,
   output logic busy,
   output logic doneStrobe,
   // Accumulator write-back and skip result
   output logic acWrite,
   output logic [1:0] acWriteIdx,
   output logic [15:0] acWriteData,
   output logic skipValid,
   output logic skipTaken,
   // Peripheral I/O bus side
   input wire logic [5:0] ackCode,
   output logic maskStrobe,
   output logic [15:0] maskData,
   output logic ioResetPulse,
   // Front pins
   input wire logic [15:0] switchesPin,
   input wire logic powerFailPin,
   input wire logic restartPin,
   // Processor state
   output logic ionFlag,
   output logic intAllowed,
   output logic pfFlag,
   output logic pfIrq,
   output logic mode64k,
   output logic halted,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   output logic irq
);
   import csd_pkg::*;

   // Settle a vector: take the new value only where stages two and three agree
   function automatic logic [PIN_W-1:0] settle(input logic [PIN_W-1:0] s2,
                                               input logic [PIN_W-1:0] s3,
                                               input logic [PIN_W-1:0] old);
      logic [PIN_W-1:0] diff;
      diff = s2 ^ s3;
      settle = (s3 & ~diff) | (old & diff);
   endfunction

   csd_state_t state; // Sequencer state
   csd_instr_t cur; // Latched instruction
   logic [PIN_W-1:0] pinS1, pinS2, pinS3, pinFilt; // Pin synchroniser
   logic pfLast, rsLast; // Edge history of settled pins
   logic ionHold; // Blocks interrupts for one instruction
   logic [EV_COUNT-1:0] status; // Sticky events
   logic [EV_COUNT-1:0] mask; // Interrupt mask

   // Decode of the incoming word
   wire isIo = (instr.cls == IO_CLASS);
   wire isCpu = isIo && (instr.dev == CPU_CODE);
   wire take = exec && (state == CSD_IDLE) && isCpu;

   // Decode of the latched word
   wire isSkip = (cur.op == OP_SKIP);
   wire ctlStart = !isSkip && (cur.ctrl == CT_START);
   wire ctlClear = !isSkip && (cur.ctrl == CT_CLEAR);
   wire ctlPulse = !isSkip && (cur.ctrl == CT_PULSE);
   wire modeSel = (cur.op == OP_NONE) && ctlPulse;
   wire global_io_reset_op = (cur.op == OP_RDC);
   wire haltOp = (cur.op == OP_WRC);
   wire loadAc = (cur.op == OP_RDA) || (cur.op == OP_RDB);

   // Settled pins
   wire [15:0] swFilt = pinFilt[15:0];
   wire pfFilt = pinFilt[PIN_PF];
   wire rsFilt = pinFilt[PIN_RS];
   wire pfRise = pfFilt && !pfLast;
   wire restartEv = (rsFilt && !rsLast) ||
                    (regWr && regAddr == REG_CTRL && regWdata[CT_RESTART]);

   // Skip condition per control select
   logic skipCond;
   always_comb begin
      case (cur.ctrl)
         CT_NONE: skipCond = ionFlag;
         CT_START: skipCond = !ionFlag;
         CT_CLEAR: skipCond = pfFlag;
         default: skipCond = !pfFlag;
      endcase
   end

   // Data chosen for the accumulator load
   wire [15:0] loadData = (cur.op == OP_RDA) ? swFilt : {10'h0, ackCode};

   // Register write decode
   wire wrStatus = regWr && (regAddr == REG_STATUS);
   wire wrMask = regWr && (regAddr == REG_MASK);
   wire pfClr = regWr && (regAddr == REG_CTRL) && regWdata[CT_PFCLR];

   // Events raised this cycle
   wire [EV_COUNT-1:0] events = {maskStrobe, pfRise, ioResetPulse,
                                 (state == CSD_CTRL) && haltOp};

   // Read mux, unmapped read_switches_op give zero
   wire [31:0] rdVal = (regAddr == REG_STATUS) ? {28'h0, status} :
                       (regAddr == REG_MASK) ? {28'h0, mask} :
                       (regAddr == REG_STATE) ? {27'h0, halted, mode64k, pfFlag,
                                                 intAllowed, ionFlag} : 32'h0;

   // Handshake and level outputs
   assign busy = (state != CSD_IDLE);
   assign halted = (state == CSD_HALT);
   assign intAllowed = ionFlag && !ionHold;
   assign pfIrq = pfFlag && ionFlag;
   assign irq = |(status & mask);

   // Three-stage pin synchroniser; only stage two read_switches_op stage one
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pinS1 <= '0;
         pinS2 <= '0;
         pinS3 <= '0;
         pinFilt <= '0;
      end else begin
         pinS1 <= {restartPin, powerFailPin, switchesPin};
         pinS2 <= pinS1;
         pinS3 <= pinS2;
         pinFilt <= settle(pinS2, pinS3, pinFilt);
      end
   end

   // Edge history for power fail and restart
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pfLast <= 1'b0;
         rsLast <= 1'b0;
      end else begin
         pfLast <= pfFilt;
         rsLast <= rsFilt;
      end
   end

   // Sequencer: accept, transfer, control, optional halt
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= CSD_IDLE;
         cur <= '0;
      end else begin
         case (state)
            CSD_IDLE: begin
               if (take) begin
                  cur <= instr;
                  state <= CSD_XFER;
               end
            end
            CSD_XFER: state <= CSD_CTRL;
            CSD_CTRL: state <= haltOp ? CSD_HALT : CSD_IDLE;
            default: begin
               // Only the operator gets us out
               if (restartEv) begin
                  state <= CSD_IDLE;
               end
            end
         endcase
      end
   end

   // Transfer stage outputs: one-cycle strobes, index, data and skip result held until the next transfer
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         acWrite <= 1'b0;
         acWriteIdx <= 2'h0;
         acWriteData <= 16'h0;
         maskStrobe <= 1'b0;
         maskData <= 16'h0;
         skipValid <= 1'b0;
         skipTaken <= 1'b0;
      end else begin
         acWrite <= (state == CSD_XFER) && loadAc;
         maskStrobe <= (state == CSD_XFER) && (cur.op == OP_WRB);
         skipValid <= (state == CSD_XFER) && isSkip;
         if (state == CSD_XFER) begin
            acWriteIdx <= cur.ac;
            acWriteData <= loadData;
            maskData <= acSel;
            skipTaken <= isSkip && skipCond;
         end
      end
   end

   // Control stage: pulses go out after the transfer
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ioResetPulse <= 1'b0;
         doneStrobe <= 1'b0;
      end else begin
         ioResetPulse <= (state == CSD_CTRL) && global_io_reset_op;
         doneStrobe <= (state == CSD_CTRL);
      end
   end

   // Interrupt-on flag and its one-instruction hold-off
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ionFlag <= 1'b0;
         ionHold <= 1'b0;
      end else begin
         if (state == CSD_CTRL && ctlStart) begin
            ionFlag <= 1'b1;
         end else if (state == CSD_CTRL && ctlClear) begin
            ionFlag <= 1'b0;
         end
         // Hold releases on the first completion after enabling
         if (state == CSD_CTRL && ctlStart) begin
            ionHold <= 1'b1;
         end else if (instrDone) begin
            ionHold <= 1'b0;
         end
      end
   end

   // Addressing mode; I/O reset forces the small map
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mode64k <= 1'b0;
      end else if (state == CSD_CTRL && global_io_reset_op) begin
         mode64k <= 1'b0;
      end else if (state == CSD_CTRL && modeSel) begin
         mode64k <= acZero[0];
      end
   end

   // Power-fail flag; a new failure beats a software clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pfFlag <= 1'b0;
      end else if (pfRise) begin
         pfFlag <= 1'b1;
      end else if (pfClr) begin
         pfFlag <= 1'b0;
      end
   end

   // Sticky status (write one to clear, set wins) and mask
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         status <= STATUS_RST;
         mask <= MASK_RST;
      end else begin
         status <= (status & ~(wrStatus ? regWdata[EV_COUNT-1:0] : 4'h0)) | events;
         if (wrMask) begin
            mask <= regWdata[EV_COUNT-1:0];
         end
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         regRdata <= 32'h0;
      end else begin
         regRdata <= regRd ? rdVal : 32'h0;
      end
   end

   // Foreign device codes never start the sequencer
   a_foreign_code_ignored: assert property (@(posedge mclk) disable iff (rst)
      (state == CSD_IDLE && exec && !isCpu) |=> (state == CSD_IDLE))
      else $error("foreign device code started the sequencer");

   // Switch read lands in the accumulator
   a_switch_read_load: assert property (@(posedge mclk) disable iff (rst)
      (state == CSD_XFER && cur.op == OP_RDA) |=> (acWrite && acWriteData == $past(swFilt)))
      else $error("switch read did not load the accumulator");

   // Enabling sets the flag but holds off interrupts
   a_ion_set_hold: assert property (@(posedge mclk) disable iff (rst)
      (state == CSD_CTRL && ctlStart) |=> (ionFlag && !intAllowed))
      else $error("interrupt enable hold-off wrong");

   // Clear control drops the flag
   a_ion_clear_ctl: assert property (@(posedge mclk) disable iff (rst)
      (state == CSD_CTRL && ctlClear) |=> !ionFlag)
      else $error("clear control left interrupts on");

   // Address mode follows accumulator zero LSB
   a_mode_from_ac: assert property (@(posedge mclk) disable iff (rst)
      (state == CSD_CTRL && modeSel && !global_io_reset_op) |=> (mode64k == $past(acZero[0])))
      else $error("addressing mode not taken from accumulator zero");

   // Acknowledge returns the requesting code
   a_ack_code_load: assert property (@(posedge mclk) disable iff (rst)
      (state == CSD_XFER && cur.op == OP_RDB) |=> (acWrite && acWriteData == {10'h0, $past(ackCode)}))
      else $error("acknowledge code not returned");

   // Mask broadcast carries the accumulator
   a_mask_broadcast: assert property (@(posedge mclk) disable iff (rst)
      (state == CSD_XFER && cur.op == OP_WRB) |=> (maskStrobe && maskData == $past(acSel)))
      else $error("mask word not broadcast");

   // I/O reset comes with 32K mode and no load
   a_io_reset_mode: assert property (@(posedge mclk) disable iff (rst)
      ioResetPulse |-> (!mode64k && !acWrite && doneStrobe))
      else $error("I/O reset side effects wrong");

   // Halt persists until restart
   a_halt_persist: assert property (@(posedge mclk) disable iff (rst)
      (halted && !restartEv) |=> halted)
      else $error("left halt without restart");

   // Busy skip reflects interrupt-on
   a_skip_busy_ion: assert property (@(posedge mclk) disable iff (rst)
      (state == CSD_XFER && cur.op == OP_SKIP && cur.ctrl == CT_NONE)
      |=> (skipValid && skipTaken == $past(ionFlag)))
      else $error("busy skip does not follow interrupt-on");

   // Power-fail interrupt only while enabled
   a_pf_irq_gate: assert property (@(posedge mclk) disable iff (rst)
      pfRise |=> (pfFlag && (pfIrq == ionFlag)))
      else $error("power-fail interrupt gating wrong");

   // Channel C never moves data
   a_chan_c_quiet: assert property (@(posedge mclk) disable iff (rst)
      (state == CSD_XFER && (global_io_reset_op || haltOp)) |=> (!acWrite && !maskStrobe))
      else $error("channel C moved data");

   // Transfer precedes the control stage
   a_xfer_then_ctl: assert property (@(posedge mclk) disable iff (rst)
      (acWrite || maskStrobe) |=> (doneStrobe && !acWrite && !maskStrobe))
      else $error("control stage did not follow transfer");

endmodule
`default_nettype wire

/* dv/csd_periph_model.sv */
// Peripheral-side model: per-device disable flags and interrupt requests
`timescale 1ns/1ps
`default_nettype none
module csd_periph_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Broadcasts from the processor
   input wire logic maskStrobe,
   input wire logic [15:0] maskData,
   input wire logic ioResetPulse,
   // Device request lines, one device per bit
   input wire logic [15:0] reqVec,
   // Acknowledge code and flags seen by the bench
   output logic [5:0] ackCode,
   output logic [15:0] disFlags
);
   // Lowest bit wins; device code is bit number plus one, zero when none
   always_comb begin
      ackCode = 6'h0;
      for (int i = 15; i >= 0; i--) begin
         if (reqVec[i] && !disFlags[i]) begin
            ackCode = 6'(i + 1);
         end
      end
   end

   // Each device takes its own mask bit; reset wins over a broadcast
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         disFlags <= 16'h0;
      end else if (ioResetPulse) begin
         disFlags <= 16'h0;
      end else if (maskStrobe) begin
         disFlags <= maskData;
      end
   end
endmodule
`default_nettype wire

/* dv/csd_decoder_tb_top.sv */
// Directed bench for the processor-code I/O decoder
`timescale 1ns/1ps
`default_nettype none
module csd_decoder_tb_top;
   import csd_pkg::*;
   // Stimulus
   logic mclk = 1'h0;
   logic rst = 1'h1;
   logic exec = 1'h0;
   logic instrDone = 1'h0;
   csd_instr_t instr = '0;
   logic [15:0] acSel = 16'h0;
   logic [15:0] acZero = 16'h0;
   logic [15:0] switchesPin = 16'h0;
   logic [15:0] reqVec = 16'h0;
   logic powerFailPin = 1'h0;
   logic restartPin = 1'h0;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0;
   logic regWr = 1'h0;
   logic regRd = 1'h0;
   // Design outputs
   logic busy, doneStrobe, acWrite, skipValid, skipTaken, maskStrobe, ioResetPulse;
   logic ionFlag, intAllowed, pfFlag, pfIrq, mode64k, halted, irq;
   logic [1:0] acWriteIdx;
   logic [15:0] acWriteData, maskData, disFlags;
   logic [5:0] ackCode;
   logic [31:0] regRdata;
   // Captured pulses and counters
   logic sawAcw, sawSkip, skTaken, sawIor;
   logic [31:0] rd;
   int bad_count = 0;
   int n_tests = 0;

   // 25 MHz clock
   always #20 mclk = ~mclk;

   csd_decoder u_dut (.mclk(mclk), .rst(rst), .exec(exec), .instr(instr), .acSel(acSel),
      .acZero(acZero), .instrDone(instrDone), .busy(busy), .doneStrobe(doneStrobe),
      .acWrite(acWrite), .acWriteIdx(acWriteIdx), .acWriteData(acWriteData),
      .skipValid(skipValid), .skipTaken(skipTaken), .ackCode(ackCode),
      .maskStrobe(maskStrobe), .maskData(maskData), .ioResetPulse(ioResetPulse),
      .switchesPin(switchesPin), .powerFailPin(powerFailPin), .restartPin(restartPin),
      .ionFlag(ionFlag), .intAllowed(intAllowed), .pfFlag(pfFlag), .pfIrq(pfIrq),
      .mode64k(mode64k), .halted(halted), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));

   csd_periph_model u_dev (.mclk(mclk), .rst(rst), .maskStrobe(maskStrobe),
      .maskData(maskData), .ioResetPulse(ioResetPulse), .reqVec(reqVec),
      .ackCode(ackCode), .disFlags(disFlags));

   // Compare and count
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One instruction; answer cycles are fixed, so no polling is needed
   task automatic run(input logic [2:0] op, input logic [1:0] ct, input logic [1:0] ac,
                      input logic [5:0] dev);
      @(posedge mclk);
      exec <= 1'h1;
      instr <= '{cls: IO_CLASS, ac: ac, op: op, ctrl: ct, dev: dev};
      @(posedge mclk);
      exec <= 1'h0;
      // Transfer pulses stand only in the cycle after the transfer edge
      @(posedge mclk);
      #1;
      sawAcw = acWrite;
      sawSkip = skipValid;
      skTaken = skipTaken;
      @(posedge mclk);
      #1;
      sawIor = ioResetPulse;
      chk("done", doneStrobe, dev == CPU_CODE);
   endtask

   // Register write, one strobe cycle
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'h1;
      @(posedge mclk);
      regWr <= 1'h0;
   endtask

   // Register read, data in the following cycle
   task automatic rdr(input logic [3:0] a);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'h1;
      @(posedge mclk);
      regRd <= 1'h0;
      #1;
      rd = regRdata;
   endtask

   // All four skip codes for a known flag pair; skips leave the flag alone
   task automatic skips(input logic interrupt_on_flag, input logic pf);
      logic [1:0] c;
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         run(OP_SKIP, c, 2'h0, CPU_CODE);
         chk("skip", {sawSkip, skTaken}, {1'h1, (c[1] ? pf : interrupt_on_flag) ^ c[0]});
         chk("skip_ion", ionFlag, interrupt_on_flag);
      end
   endtask

   // Verdict and end of run
   task automatic print_verdict;
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Watchdog, well past the directed sequence
   initial begin
      repeat (5000) @(posedge mclk);
      bad_count++;
      print_verdict;
   end

   // Directed sequence
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'h0;
      switchesPin <= 16'ha5c3;
      reqVec <= 16'h0030;
      acSel <= 16'h0010;
      rdr(REG_STATE);
      chk("state_rst", rd, 32'h0);
      rdr(4'h2);
      chk("unmapped", rd, 32'h0);
      // Ordinary device code must be ignored
      run(OP_RDA, CT_START, 2'h0, 6'h08);
      chk("ion_other", ionFlag, 1'h0);
      // Switch read with start; hold-off until one instruction completes
      run(OP_RDA, CT_START, 2'h2, CPU_CODE);
      chk("sw", {sawAcw, acWriteIdx, acWriteData}, {1'h1, 2'h2, 16'ha5c3});
      chk("ion_set", {ionFlag, intAllowed}, 2'h2);
      @(posedge mclk);
      instrDone <= 1'h1;
      @(posedge mclk);
      instrDone <= 1'h0;
      #1;
      chk("int_ok", intAllowed, 1'h1);
      run(OP_WRA, CT_NONE, 2'h1, CPU_CODE);
      chk("wra", sawAcw, 1'h0);
      // Acknowledge, then masks narrow and finally block all devices
      run(OP_RDB, CT_NONE, 2'h1, CPU_CODE);
      chk("ack1", {sawAcw, acWriteData}, {1'h1, 16'h0005});
      run(OP_WRB, CT_NONE, 2'h1, CPU_CODE);
      chk("mask1", disFlags, 16'h0010);
      run(OP_RDB, CT_NONE, 2'h1, CPU_CODE);
      chk("ack2", acWriteData, 16'h0006);
      @(posedge mclk);
      acSel <= 16'hffff;
      run(OP_WRB, CT_NONE, 2'h1, CPU_CODE);
      run(OP_RDB, CT_NONE, 2'h1, CPU_CODE);
      chk("mask_all", {disFlags, acWriteData}, {16'hffff, 16'h0});
      run(OP_NONE, CT_CLEAR, 2'h0, CPU_CODE);
      chk("ion_clr", ionFlag, 1'h0);
      // Address mode from bit zero of accumulator zero
      @(posedge mclk);
      acZero <= 16'hfffe;
      run(OP_NONE, CT_PULSE, 2'h0, CPU_CODE);
      chk("mode0", mode64k, 1'h0);
      @(posedge mclk);
      acZero <= 16'h0001;
      run(OP_NONE, CT_PULSE, 2'h0, CPU_CODE);
      chk("mode1", mode64k, 1'h1);
      run(OP_NONE, CT_START, 2'h0, CPU_CODE);
      skips(1'h1, 1'h0);
      // Reset of all devices, no data moved
      run(OP_RDC, CT_CLEAR, 2'h0, CPU_CODE);
      chk("global_io_reset_op", {sawIor, sawAcw, ionFlag, mode64k}, 4'h8);
      rdr(REG_STATUS);
      chk("status", rd, 32'h0a);
      // Devices drop their flags one edge after the reset pulse
      chk("global_io_reset_op_dev", disFlags, 16'h0);
      wr(REG_STATUS, 32'hf);
      rdr(REG_STATUS);
      chk("w1c", rd, 32'h0);
      // Power fail raises flag; interrupt only with interrupt-on
      wr(REG_MASK, 32'h4);
      powerFailPin <= 1'h1;
      repeat (8) @(posedge mclk);
      #1;
      chk("pf", {pfFlag, pfIrq, irq}, 3'h5);
      skips(1'h0, 1'h1);
      run(OP_NONE, CT_START, 2'h0, CPU_CODE);
      chk("pf_irq", pfIrq, 1'h1);
      @(posedge mclk);
      powerFailPin <= 1'h0;
      wr(REG_STATUS, 32'h4);
      wr(REG_CTRL, 32'h1);
      rdr(REG_STATE);
      chk("pf_clr", {irq, rd}, {1'h0, 32'h1});
      // Halt holds until an operator restart
      run(OP_WRC, CT_NONE, 2'h0, CPU_CODE);
      repeat (4) @(posedge mclk);
      #1;
      chk("halt", {halted, busy, sawAcw}, 3'h6);
      wr(REG_CTRL, 32'h2);
      repeat (2) @(posedge mclk);
      #1;
      chk("restart", {halted, busy}, 2'h0);
      // Second halt, released from the front pin through the synchroniser
      run(OP_WRC, CT_NONE, 2'h0, CPU_CODE);
      chk("halt2", halted, 1'h1);
      @(posedge mclk);
      restartPin <= 1'h1;
      repeat (6) @(posedge mclk);
      #1;
      chk("restart_pin", {halted, busy}, 2'h0);
      @(posedge mclk);
      restartPin <= 1'h0;
      rdr(REG_STATUS);
      chk("halt_ev", rd, 32'h1);
      print_verdict;
   end
endmodule
`default_nettype wire
